// File: logic/mmc_pkg.sv
// Shared constants and types for the module management control block
package mmc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_MHZ       = 100;
  localparam int T_INIT_MS     = 2000;
  localparam int T_RST_REC_US  = 2;
  localparam int T_RST_FILT_NS = 1000;
  localparam int RST_FILT_CYC  = T_RST_FILT_NS * CLK_MHZ / 1000;
  localparam int INIT_CYC_DEF  = T_INIT_MS * 1000 * CLK_MHZ;

  ////////////////////////////////////////////////////////////////////////////
  // Serial address and lower page map
  localparam logic [6:0] DEV_ADDR    = 7'h50;
  localparam logic [7:0] OFS_STATUS  = 8'h02;
  localparam logic [7:0] OFS_FLAG_A  = 8'h03;
  localparam logic [7:0] OFS_FLAG_B  = 8'h04;
  localparam logic [7:0] OFS_MON     = 8'h16;
  localparam logic [7:0] OFS_PWR     = 8'h5D;
  localparam logic [7:0] OFS_MASK_A  = 8'h64;
  localparam logic [7:0] OFS_MASK_B  = 8'h65;
  localparam logic [7:0] OFS_PAGE    = 8'h7F;
  localparam int         MON_BYTES   = 8;
  localparam int         PAGE_W      = 2;
  localparam int         LOWER_SIZE  = 128;
  localparam int         UPPER_SIZE  = LOWER_SIZE << PAGE_W;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [PAGE_W-1:0] PAGE_RST  = 2'h0;
  localparam logic [15:0]       MASK_RST  = 16'h0000;
  localparam logic              PDOWN_RST = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic [3:0] rx_los;
    logic [3:0] tx_fault;
    logic [7:0] other;
  } mmc_cond_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       stop;
    logic [7:0] addr;
    logic [7:0] data;
  } mmc_req_t;

  typedef enum logic [2:0] {
    TW_IDLE     = 3'h0,
    TW_ADDR     = 3'h1,
    TW_ACK_ADDR = 3'h2,
    TW_WRITE    = 3'h3,
    TW_ACK_WR   = 3'h4,
    TW_READ     = 3'h5,
    TW_ACK_RD   = 3'h6
  } mmc_twi_st_t;

endpackage

// File: logic/mmc_twi.sv
// Two-wire serial target with byte-level request port
`timescale 1ns/10ps
module mmc_twi
  import mmc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       en,
  // Bus pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_oe,
  // Byte port
  input  wire logic [7:0] rdata,
  output logic [7:0]      cur_addr,
  output mmc_req_t        req
);

  logic        scl_m_q, scl_s_q, scl_p_q;
  logic        sda_m_q, sda_s_q, sda_p_q;
  mmc_twi_st_t st_q;
  logic [3:0]  cnt_q;
  logic [7:0]  sh_q;
  logic [7:0]  addr_q;
  logic        first_q;
  logic        rw_q;
  logic        ack_q;
  logic        oe_q;
  mmc_req_t    req_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling, SCL is treated as data and edge-detected
  always_ff @(posedge clk) begin
    if (srst) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {scl_i, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {sda_i, sda_m_q, sda_s_q};
    end
  end

  wire rise    = scl_s_q & ~scl_p_q;
  wire fall    = ~scl_s_q & scl_p_q;
  wire start   = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire stop    = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  wire do_load = fall & ((st_q == TW_ACK_ADDR & rw_q) | (st_q == TW_ACK_RD & ack_q));

  ////////////////////////////////////////////////////////////////////////////
  // Byte engine
  always_ff @(posedge clk) begin
    if (srst || !en) begin
      st_q    <= TW_IDLE;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      addr_q  <= 8'h00;
      first_q <= 1'b0;
      rw_q    <= 1'b0;
      ack_q   <= 1'b0;
      oe_q    <= 1'b0;
      req_q   <= '0;
    end else begin
      req_q.wr   <= 1'b0;
      req_q.rd   <= 1'b0;
      req_q.stop <= 1'b0;
      if (start) begin
        st_q  <= TW_ADDR;
        cnt_q <= 4'h0;
        oe_q  <= 1'b0;
      end else if (stop) begin
        // A read ends idle after its nack, so every stop must close the transfer
        req_q.stop <= 1'b1;
        st_q       <= TW_IDLE;
        oe_q       <= 1'b0;
      end else if (do_load) begin
        // Snapshot goes out with the strobe so only shown bits get cleared
        sh_q       <= rdata;
        oe_q       <= ~rdata[7];
        cnt_q      <= 4'h0;
        req_q.rd   <= 1'b1;
        req_q.addr <= addr_q;
        req_q.data <= rdata;
        addr_q     <= addr_q + 8'h01;
        st_q       <= TW_READ;
      end else begin
        unique case (st_q)
          TW_IDLE: ;
          TW_ADDR, TW_WRITE: begin
            if (rise && cnt_q != 4'h8) begin
              sh_q  <= {sh_q[6:0], sda_s_q};
              cnt_q <= cnt_q + 4'h1;
            end else if (fall && cnt_q == 4'h8) begin
              cnt_q <= 4'h0;
              if (st_q == TW_ADDR) begin
                if (sh_q[7:1] == DEV_ADDR) begin
                  oe_q <= 1'b1;
                  rw_q <= sh_q[0];
                  st_q <= TW_ACK_ADDR;
                end else begin
                  st_q <= TW_IDLE;
                end
              end else begin
                oe_q    <= 1'b1;
                st_q    <= TW_ACK_WR;
                first_q <= 1'b0;
                if (first_q) begin
                  addr_q <= sh_q;
                end else begin
                  req_q.wr   <= 1'b1;
                  req_q.addr <= addr_q;
                  req_q.data <= sh_q;
                  addr_q     <= addr_q + 8'h01;
                end
              end
            end
          end
          TW_ACK_ADDR: begin
            if (fall) begin
              oe_q    <= 1'b0;
              first_q <= 1'b1;
              st_q    <= TW_WRITE;
            end
          end
          TW_ACK_WR: begin
            if (fall) begin
              oe_q <= 1'b0;
              st_q <= TW_WRITE;
            end
          end
          TW_READ: begin
            if (rise) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (fall) begin
              if (cnt_q == 4'h8) begin
                oe_q <= 1'b0;
                st_q <= TW_ACK_RD;
              end else begin
                sh_q <= {sh_q[6:0], 1'b0};
                oe_q <= ~sh_q[6];
              end
            end
          end
          TW_ACK_RD: begin
            if (rise) begin
              ack_q <= ~sda_s_q;
            end else if (fall) begin
              st_q <= TW_IDLE;
            end
          end
          default: st_q <= TW_IDLE;
        endcase
      end
    end
  end

  assign sda_oe   = oe_q;
  assign cur_addr = addr_q;
  assign req      = req_q;

endmodule // mmc_twi

// File: logic/mmc_top.sv
// Management and control logic of a pluggable transceiver module
// Operation
// - One always-visible 128-byte lower page plus one paged 128-byte upper window.
// - Identity and threshold data live in upper pages chosen by page select.
// - Device answers serial management transfers at address A0h.
// - Flags and monitor values sit in the lower page for one-pass reads.
// - Fully functional within 2000 ms of power on or hot insertion.
// - Reset low beyond minimum pulse resets device, recognised within 2 us.
// - Serial bus answers within 2000 ms of power on.
// - Data-not-ready bit clears and interrupt asserts within 2000 ms.
// - Fully functional means interrupt asserted by data-not-ready clearing.
// - Fully functional within 2000 ms of reset input rising edge.
// - Low-power pin high drops device to low power within 100 us.
// - Interrupt output goes low within 200 ms of a triggering condition.
// - Flags clear on read, interrupt releases within 500 us afterwards.
// - Receive loss of signal sets its flag and interrupt within 100 ms.
// - Any other condition sets its flag and interrupt within 200 ms.
// - Setting a mask bit stops its flag driving interrupt within 100 ms.
// - Clearing a mask bit lets its flag drive interrupt within 100 ms.
// - Serial answers start and stop within 100 us of module select.
// - Power-down bit enters low power in 100 ms, leaves in 300 ms.
// - Write-triggered timing counts from the edge after the write stop.
`timescale 1ns/10ps
module mmc_top
  import mmc_pkg::*;
#(
  parameter int unsigned INIT_CYC = INIT_CYC_DEF
) (
  // Clock and reset
  input  wire logic                     MCLK,
  input  wire logic                     SRST,
  // Two-wire serial pins
  input  wire logic                     SCL_I,
  input  wire logic                     SDA_I,
  output logic                          SDA_O,
  output logic                          SDA_OE,
  // Discrete pins
  input  wire logic                     MODULE_RESET_N,
  input  wire logic                     MODULE_SELECT_N,
  input  wire logic                     LOW_POWER_PIN,
  output logic                          INTERRUPT_OUT_N,
  output logic                          MODULE_PRESENT_N,
  // Internal conditions and monitors
  input  mmc_cond_t                     COND,
  input  wire logic [8*MON_BYTES-1:0]   MON_DATA,
  // Status
  output logic                          LOW_POWER,
  output logic                          READY
);

  logic [2:0]        pin_m_q;
  logic [2:0]        pin_s_q;
  logic [7:0]        rst_cnt_q;
  logic              mod_rst_q;
  logic [27:0]       init_cnt_q;
  logic              ready_q;
  logic              init_flag_q;
  logic              iclr_q;
  logic [15:0]       flag_q;
  logic [15:0]       clr_q;
  logic [15:0]       mask_q;
  logic [PAGE_W-1:0] page_q;
  logic              pdown_q;
  logic              irq_q;
  logic              lowp_q;
  logic [7:0]        up_mem [UPPER_SIZE];
  mmc_req_t          req;
  logic [7:0]        cur_addr;
  logic              twi_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: bit 2 reset, bit 1 select, bit 0 low power
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      pin_m_q <= 3'h6;
      pin_s_q <= 3'h6;
    end else begin
      pin_m_q <= {MODULE_RESET_N, MODULE_SELECT_N, LOW_POWER_PIN};
      pin_s_q <= pin_m_q;
    end
  end

  wire rst_n_s   = pin_s_q[2];
  wire sel_n_s   = pin_s_q[1];
  wire lp_s      = pin_s_q[0];
  wire rst_all   = SRST | mod_rst_q;
  wire rst_full  = rst_cnt_q == 8'(RST_FILT_CYC);
  wire init_end  = !ready_q && init_cnt_q == 28'(INIT_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin filter; short glitches never reach the management state
  always_ff @(posedge MCLK) begin
    if (SRST || rst_n_s) begin
      rst_cnt_q <= 8'h00;
      mod_rst_q <= 1'b0;
    end else if (rst_full) begin
      mod_rst_q <= 1'b1;
    end else begin
      rst_cnt_q <= rst_cnt_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start-up timer and data-not-ready status
  always_ff @(posedge MCLK) begin
    if (rst_all) begin
      init_cnt_q <= 28'h0000000;
      ready_q    <= 1'b0;
    end else if (init_end) begin
      ready_q    <= 1'b1;
    end else if (!ready_q) begin
      init_cnt_q <= init_cnt_q + 28'h0000001;
    end
  end

  // Set wins over a clear-on-read in the same cycle
  wire init_flag_d = init_end | (init_flag_q & ~(req.stop & iclr_q));

  ////////////////////////////////////////////////////////////////////////////
  // Flags: latched, cleared at the stop of the read that showed them
  wire [15:0] cond_w   = COND;
  wire [15:0] clr_fire = req.stop ? clr_q : 16'h0000;
  wire [15:0] flag_d   = (flag_q & ~clr_fire) | cond_w;
  wire        rd_a     = req.rd && req.addr == OFS_FLAG_A;
  wire        rd_b     = req.rd && req.addr == OFS_FLAG_B;
  wire        rd_st    = req.rd && req.addr == OFS_STATUS;

  always_ff @(posedge MCLK) begin
    if (rst_all) begin
      flag_q      <= 16'h0000;
      clr_q       <= 16'h0000;
      iclr_q      <= 1'b0;
      init_flag_q <= 1'b0;
    end else begin
      flag_q      <= flag_d;
      init_flag_q <= init_flag_d;
      if (req.stop) begin
        clr_q  <= 16'h0000;
        iclr_q <= 1'b0;
      end else begin
        clr_q  <= clr_q | {rd_a ? req.data : 8'h00, rd_b ? req.data : 8'h00};
        iclr_q <= iclr_q | rd_st;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host-written control bytes, applied as the data byte completes
  wire wr_lo = req.wr && !req.addr[7];

  always_ff @(posedge MCLK) begin
    if (rst_all) begin
      mask_q  <= MASK_RST;
      page_q  <= PAGE_RST;
      pdown_q <= PDOWN_RST;
    end else if (wr_lo) begin
      if (req.addr == OFS_MASK_A) mask_q[15:8] <= req.data;
      if (req.addr == OFS_MASK_B) mask_q[7:0] <= req.data;
      if (req.addr == OFS_PAGE) page_q <= req.data[PAGE_W-1:0];
      if (req.addr == OFS_PWR) pdown_q <= req.data[0];
    end
  end

  // Upper window holds data only, so it keeps its content through reset
  always_ff @(posedge MCLK) begin
    if (req.wr && req.addr[7]) begin
      up_mem[{page_q, req.addr[6:0]}] <= req.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt and power outputs
  wire irq_d = (|(flag_q & ~mask_q)) | init_flag_q;

  always_ff @(posedge MCLK) begin
    if (rst_all) begin
      irq_q  <= 1'b0;
      lowp_q <= 1'b0;
    end else begin
      irq_q  <= irq_d;
      lowp_q <= lp_s | pdown_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data; everything tied to an interrupt sits in the lower page
  function automatic logic [7:0] lower_byte(input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == OFS_STATUS[6:0]) v = {7'h00, ~ready_q};
    if (a == OFS_FLAG_A[6:0]) v = flag_q[15:8];
    if (a == OFS_FLAG_B[6:0]) v = flag_q[7:0];
    if (a == OFS_MASK_A[6:0]) v = mask_q[15:8];
    if (a == OFS_MASK_B[6:0]) v = mask_q[7:0];
    if (a == OFS_PWR[6:0]) v = {7'h00, pdown_q};
    if (a == OFS_PAGE[6:0]) v = {6'h00, page_q};
    if (a >= OFS_MON[6:0] && a < OFS_MON[6:0] + 7'(MON_BYTES)) begin
      v = MON_DATA[8*(a - OFS_MON[6:0]) +: 8];
    end
    return v;
  endfunction

  wire [7:0] rdata = cur_addr[7] ? up_mem[{page_q, cur_addr[6:0]}]
                                 : lower_byte(cur_addr[6:0]);

  // Bus is quiet while deselected or held in reset
  wire twi_en = !sel_n_s && !rst_all;

  mmc_twi u_twi (
    .clk      (MCLK),
    .srst     (SRST),
    .en       (twi_en),
    .scl_i    (SCL_I),
    .sda_i    (SDA_I),
    .sda_oe   (twi_oe),
    .rdata    (rdata),
    .cur_addr (cur_addr),
    .req      (req)
  );

  assign SDA_O            = 1'b0;
  assign SDA_OE           = twi_oe;
  assign INTERRUPT_OUT_N  = ~irq_q;
  assign MODULE_PRESENT_N = 1'b0;
  assign LOW_POWER        = lowp_q;
  assign READY            = ready_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (rst_all);

  a_rst_recog: assert property (disable iff (SRST)
    $fell(rst_n_s) |-> ##[1:101] mod_rst_q || rst_n_s)
    else $error("reset pin not recognised in time");
  a_rst_quiet: assert property (disable iff (SRST)
    mod_rst_q |=> !SDA_OE && INTERRUPT_OUT_N)
    else $error("activity while held in reset");
  a_init_time: assert property (
    $rose(ready_q) |-> $past(init_cnt_q) == 28'(INIT_CYC - 1))
    else $error("ready at wrong start-up count");
  a_dnr_irq: assert property (
    $rose(ready_q) |=> !INTERRUPT_OUT_N)
    else $error("no interrupt when data became ready");
  a_flag_irq: assert property (
    |(flag_q & ~mask_q) |=> !INTERRUPT_OUT_N)
    else $error("unmasked flag without interrupt");
  a_los_flag: assert property (
    COND.rx_los[0] |=> flag_q[12] ##1 !INTERRUPT_OUT_N || mask_q[12])
    else $error("loss of signal not flagged");
  a_flag_hold: assert property (
    !req.stop |=> ($past(flag_q) & ~flag_q) == 16'h0000)
    else $error("flag dropped without a read");
  a_mask_off: assert property (
    (flag_q & ~mask_q) == 16'h0000 && !init_flag_q |=> INTERRUPT_OUT_N)
    else $error("masked flag still interrupts");
  a_low_power: assert property (
    lp_s || pdown_q |=> LOW_POWER)
    else $error("low power not entered");
  a_sel_off: assert property (
    sel_n_s |=> !SDA_OE)
    else $error("answering while deselected");

  ////////////////////////////////////////////////////////////////////////////
  // Byte effects and flag bookkeeping
  a_read_clr: assert property (
    req.stop |=> (flag_q & $past(clr_q) & ~$past(cond_w)) == 16'h0000)
    else $error("shown flag survived its read");
  a_start_clr: assert property (
    req.stop && iclr_q && !init_end |=> !init_flag_q)
    else $error("start flag survived its read");
  a_flag_set: assert property (
    |cond_w |=> (flag_q & $past(cond_w)) == $past(cond_w))
    else $error("condition not latched");
  a_start_irq: assert property (
    init_flag_q |=> !INTERRUPT_OUT_N)
    else $error("start flag without interrupt");
  a_ready_hold: assert property (
    ready_q |=> ready_q)
    else $error("ready dropped without reset");
  a_rst_clear: assert property (disable iff (SRST)
    mod_rst_q |=> !READY && !LOW_POWER)
    else $error("state kept while held in reset");
  a_pdown_off: assert property (
    !lp_s && !pdown_q |=> !LOW_POWER)
    else $error("low power not left");
  a_pwr_apply: assert property (
    req.wr && req.addr == OFS_PWR |=> pdown_q == $past(req.data[0]))
    else $error("power-down write not applied");
  a_mask_apply: assert property (
    req.wr && req.addr == OFS_MASK_A |=> mask_q[15:8] == $past(req.data))
    else $error("mask write not applied");
  a_page_apply: assert property (
    req.wr && req.addr == OFS_PAGE |=> page_q == $past(req.data[PAGE_W-1:0]))
    else $error("page write not applied");

  c_init_done: cover property ($rose(ready_q));
  c_read_clr: cover property (req.stop && clr_q != 16'h0000);
  c_mask_wr: cover property (wr_lo && req.addr == OFS_MASK_A);
  c_page_wr: cover property (req.wr && req.addr[7] && page_q != PAGE_RST);
  c_los_irq: cover property ($fell(INTERRUPT_OUT_N) && |flag_q[15:12]);

endmodule // mmc_top

// File: verification/mmc_host_bfm.sv
// Host board model: two-wire bus master with byte and transfer tasks
`timescale 1ns/10ps
module mmc_host_bfm (
  // Clock
  input  wire logic clk,
  // Bus wires
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  ////////////////////////////////////////
  // Serial clock stands high between frames; four clocks a phase give 40 ns
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic hw(input int n = 4);
    repeat (n) @(posedge clk);
  endtask

  // Data moves only in the low phase, so no false start or stop is seen
  task automatic bit_x(input logic b, output logic s);
    scl <= 1'b0;
    hw(2);
    sda_pull <= ~b;
    hw(2);
    scl <= 1'b1;
    hw();
    @(negedge clk);
    s = sda;
    @(posedge clk);
  endtask

  task automatic byte_x(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(tx[i], s);
      rx[i] = s;
    end
    bit_x(1'b1, s);
    ack = ~s;
  endtask

  task automatic start_c();
    scl <= 1'b0;
    hw(2);
    sda_pull <= 1'b0;
    hw(2);
    scl <= 1'b1;
    hw();
    sda_pull <= 1'b1;
    hw();
  endtask

  task automatic stop_c();
    scl <= 1'b0;
    hw(2);
    sda_pull <= 1'b1;
    hw(2);
    scl <= 1'b1;
    hw();
    sda_pull <= 1'b0;
    hw();
  endtask

  ////////////////////////////////////////
  // Offset write of one byte
  task automatic wr(input logic [7:0] ad, input logic [7:0] ofs, input logic [7:0] dat,
                    output logic ok);
    logic [7:0] r;
    logic       a0;
    logic       a1;
    logic       a2;
    start_c();
    byte_x(ad, r, a0);
    byte_x(ofs, r, a1);
    byte_x(dat, r, a2);
    stop_c();
    ok = a0 & a1 & a2;
  endtask

  // Random read: offset write, repeated start, one byte, then nack
  task automatic rd(input logic [7:0] ofs, output logic [7:0] dat, output logic ok);
    logic [7:0] r;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       n;
    start_c();
    byte_x(8'hA0, r, a0);
    byte_x(ofs, r, a1);
    start_c();
    byte_x(8'hA1, r, a2);
    byte_x(8'hFF, dat, n);
    stop_c();
    ok = a0 & a1 & a2;
  endtask
endmodule // mmc_host_bfm

// File: verification/tb_top.sv
// Self-checking bench for the module management control block
`timescale 1ns/10ps
module tb_top;
  import mmc_pkg::*;
  localparam int unsigned INIT_N = 2000;
  logic        mclk;
  logic        srst;
  logic        mod_rst_n;
  logic        mod_sel_n;
  logic        lp_pin;
  logic [63:0] mon;
  logic [7:0]  d;
  logic        ok;
  mmc_cond_t   cond;
  wire         scl;
  wire         sda_pull;
  wire         sda_oe;
  wire         sda_o;
  wire         int_n;
  wire         prs_n;
  wire         low_pwr;
  wire         ready;
  // Open-drain wire with pull-up: low while either side pulls
  wire         sda = ~(sda_pull | sda_oe);
  int          error_cnt;
  int          n_tests;

  mmc_top #(.INIT_CYC(INIT_N)) mmc_top_i (
    .MCLK(mclk), .SRST(srst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
    .MODULE_RESET_N(mod_rst_n), .MODULE_SELECT_N(mod_sel_n), .LOW_POWER_PIN(lp_pin),
    .INTERRUPT_OUT_N(int_n), .MODULE_PRESENT_N(prs_n), .COND(cond), .MON_DATA(mon),
    .LOW_POWER(low_pwr), .READY(ready)
  );
  mmc_host_bfm mmc_host_bfm_i (.clk(mclk), .sda(sda), .scl(scl), .sda_pull(sda_pull));

  ////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic final_report();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic pick(input int s);
    return (s == 0) ? int_n : (s == 1) ? ready : low_pwr;
  endfunction

  // Bounded wait on a status output, sampled away from the active edge
  task automatic wt(input int s, input logic v, input int lim, input string nm);
    int n;
    n = 0;
    @(negedge mclk);
    while (pick(s) !== v && n < lim) begin
      @(negedge mclk);
      n++;
    end
    chk(nm, {7'h00, pick(s)}, {7'h00, v});
    @(posedge mclk);
  endtask

  task automatic wrc(input logic [7:0] ofs, input logic [7:0] dat);
    mmc_host_bfm_i.wr(8'hA0, ofs, dat, ok);
    chk("write ack", {7'h00, ok}, 8'h01);
  endtask

  task automatic rdc(input logic [7:0] ofs, input logic [7:0] exp, input string nm);
    mmc_host_bfm_i.rd(ofs, d, ok);
    chk(nm, d, exp);
  endtask

  // A one-cycle condition: the flag must hold it after it has gone
  task automatic pulse(input mmc_cond_t c);
    @(posedge mclk);
    cond <= c;
    @(posedge mclk);
    cond <= '0;
    repeat (20) @(posedge mclk);
  endtask

  ////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    final_report();
  end

  initial begin
    error_cnt = 0;
    n_tests = 0;
    srst = 1'b1;
    mod_rst_n = 1'b1;
    mod_sel_n = 1'b0;
    lp_pin = 1'b0;
    cond = '0;
    mon = 64'hF1E2D3C4B5A69788;
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    @(negedge mclk);
    chk("idle outputs", {2'h0, sda_oe, sda_o, int_n, ready, low_pwr, prs_n}, 8'h08);
    repeat (3) @(posedge mclk);
    // Start-up
    rdc(8'h02, 8'h01, "not ready");
    wt(1, 1'b1, INIT_N + 10, "ready");
    wt(0, 1'b0, 3, "start int");
    rdc(8'h02, 8'h00, "data ready");
    wt(0, 1'b1, 20, "start release");
    // Foreign address gets no ack and changes nothing
    mmc_host_bfm_i.wr(8'hA2, 8'h7F, 8'h03, ok);
    chk("foreign addr", {7'h00, ok}, 8'h00);
    rdc(8'h7F, 8'h00, "page kept");
    // Upper pages share one window; page select written first
    wrc(8'h7F, 8'h01);
    wrc(8'h80, 8'h5A);
    wrc(8'h7F, 8'h02);
    wrc(8'h80, 8'hC3);
    rdc(8'h80, 8'hC3, "page two");
    wrc(8'h7F, 8'h01);
    rdc(8'h80, 8'h5A, "page one");
    rdc(8'h7F, 8'h01, "page select");
    rdc(8'h16, mon[7:0], "monitor first");
    rdc(8'h1D, mon[63:56], "monitor last");
    // Receive loss of signal
    pulse('{rx_los: 4'h1, tx_fault: 4'h0, other: 8'h00});
    chk("los int", {7'h00, int_n}, 8'h00);
    rdc(8'h03, 8'h10, "los flag");
    wt(0, 1'b1, 20, "los release");
    rdc(8'h03, 8'h00, "flag cleared");
    // Other condition
    pulse('{rx_los: 4'h0, tx_fault: 4'h0, other: 8'h80});
    chk("other int", {7'h00, int_n}, 8'h00);
    rdc(8'h04, 8'h80, "other flag");
    wt(0, 1'b1, 20, "other release");
    // Masked flag stays latched and fires once unmasked
    wrc(8'h64, 8'h0F);
    pulse('{rx_los: 4'h0, tx_fault: 4'h1, other: 8'h00});
    chk("masked int", {7'h00, int_n}, 8'h01);
    wrc(8'h64, 8'h00);
    wt(0, 1'b0, 20, "unmasked int");
    rdc(8'h03, 8'h01, "tx flag");
    wt(0, 1'b1, 20, "tx release");
    // Power-down bit and low-power pin
    wrc(8'h5D, 8'h01);
    wt(2, 1'b1, 10, "pdown on");
    rdc(8'h5D, 8'h01, "pdown bit");
    wrc(8'h5D, 8'h00);
    wt(2, 1'b0, 10, "pdown off");
    lp_pin <= 1'b1;
    wt(2, 1'b1, 8, "pin low power");
    lp_pin <= 1'b0;
    wt(2, 1'b0, 8, "pin full power");
    // Module select
    mod_sel_n <= 1'b1;
    repeat (4) @(posedge mclk);
    mmc_host_bfm_i.rd(8'h02, d, ok);
    chk("deselected", {7'h00, ok}, 8'h00);
    mod_sel_n <= 1'b0;
    repeat (4) @(posedge mclk);
    rdc(8'h7F, 8'h01, "reselected");
    // Short reset glitch is filtered, a long one resets
    mod_rst_n <= 1'b0;
    repeat (50) @(posedge mclk);
    mod_rst_n <= 1'b1;
    repeat (10) @(posedge mclk);
    chk("glitch ignored", {7'h00, ready}, 8'h01);
    mod_rst_n <= 1'b0;
    wt(1, 1'b0, 200, "reset seen");
    chk("reset int", {7'h00, int_n}, 8'h01);
    mmc_host_bfm_i.wr(8'hA0, 8'h7F, 8'h02, ok);
    chk("bus in reset", {7'h00, ok}, 8'h00);
    mod_rst_n <= 1'b1;
    wt(1, 1'b1, INIT_N + 20, "reset ready");
    rdc(8'h7F, 8'h00, "page cleared");
    final_report();
  end
endmodule // tb_top
